// >>> rtl/dsh_object_bank.sv
// object dictionary bank for gear ratio, feed constant and homing method
`timescale 1ns/1ps
`default_nettype none
module dsh_object_bank
  import dsh_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // sdo access from the fieldbus side
  input wire logic sdo_req,
  input wire logic sdo_write,
  input wire logic [15:0] sdo_index,
  input wire logic [7:0] sdo_subindex,
  input wire logic [31:0] sdo_wdata,
  output logic sdo_done,
  output logic sdo_abort,
  output logic [31:0] sdo_abort_code,
  output logic [31:0] sdo_rdata,
  // non-volatile store, one word per slot
  output logic nv_we,
  output logic [2:0] nv_addr,
  output logic [31:0] nv_wdata,
  input wire logic [31:0] nv_rdata,
  input wire logic nv_valid,
  // runtime parameter write port
  output logic par_we,
  output logic [15:0] par_num,
  output logic [31:0] par_wdata,
  // drive configuration, scaling and homing outputs
  input wire logic [7:0] drive_conf,
  output logic scaling_active,
  output logic [31:0] gear_num,
  output logic [31:0] gear_den,
  output logic [31:0] feed_num,
  output logic [31:0] feed_den,
  output logic signed [7:0] homing_method,
  output logic homing_enabled
);
  dsh_state_e st_q, st_d;
  logic [2:0] slot_q, slot_d;
  logic [31:0] gmot_q, gmot_d, gout_q, gout_d;
  logic [31:0] funit_q, funit_d, frev_q, frev_d;
  logic [7:0] home_q, home_d;
  logic done_q, done_d, abort_q, abort_d;
  logic [31:0] code_q, code_d, rdata_q, rdata_d;
  logic pwe_q, pwe_d;
  logic [15:0] pnum_q, pnum_d;
  logic [31:0] pdat_q, pdat_d;
  logic nwe_q, nwe_d;
  logic [31:0] ndat_q, ndat_d;
  logic in_range;

  // shared 1..65535 check for gear and feed unit entries
  assign in_range = (sdo_wdata >= DSH_VAL_MIN) && (sdo_wdata <= DSH_VAL_MAX);

  always_comb begin
    st_d = st_q;
    slot_d = slot_q;
    gmot_d = gmot_q;
    gout_d = gout_q;
    funit_d = funit_q;
    frev_d = frev_q;
    home_d = home_q;
    done_d = 1'b0;
    abort_d = 1'b0;
    code_d = code_q;
    rdata_d = rdata_q;
    pwe_d = 1'b0;
    pnum_d = pnum_q;
    pdat_d = pdat_q;
    nwe_d = 1'b0;
    ndat_d = ndat_q;
    case (st_q)
      DSH_ST_LOAD: begin
        // saved values override mirrored parameters at power-up
        pwe_d = nv_valid;
        pdat_d = nv_rdata;
        if (slot_q == DSH_NV_GMOT) begin
          if (nv_valid) gmot_d = nv_rdata;
          pnum_d = DSH_PAR_GEAR_MOTOR;
        end else if (slot_q == DSH_NV_GOUT) begin
          if (nv_valid) gout_d = nv_rdata;
          pnum_d = DSH_PAR_GEAR_OUT;
        end else if (slot_q == DSH_NV_FUNIT) begin
          if (nv_valid) funit_d = nv_rdata;
          pnum_d = DSH_PAR_FEED;
        end else if (slot_q == DSH_NV_FREV) begin
          if (nv_valid) frev_d = nv_rdata;
          pwe_d = 1'b0;
        end else begin
          if (nv_valid) home_d = nv_rdata[7:0];
          pnum_d = DSH_PAR_HOME;
        end
        if (slot_q == DSH_NV_HOME) begin
          slot_d = 3'd0;
          st_d = DSH_ST_IDLE;
        end else begin
          slot_d = slot_q + 3'd1;
        end
      end
      DSH_ST_SAVE: begin
        // one slot per cycle; sdo requests are ignored during the walk
        nwe_d = 1'b1;
        if (slot_q == DSH_NV_GMOT) ndat_d = gmot_q;
        else if (slot_q == DSH_NV_GOUT) ndat_d = gout_q;
        else if (slot_q == DSH_NV_FUNIT) ndat_d = funit_q;
        else if (slot_q == DSH_NV_FREV) ndat_d = frev_q;
        else ndat_d = {24'h00_0000, home_q};
        if (slot_q == DSH_NV_HOME) begin
          st_d = DSH_ST_IDLE;
          done_d = 1'b1;
        end else begin
          slot_d = slot_q + 3'd1;
        end
      end
      default: begin
        if (sdo_req) begin
          done_d = 1'b1;
          rdata_d = 32'h0000_0000;
          if (sdo_index == DSH_IDX_GEAR || sdo_index == DSH_IDX_FEED) begin
            if (sdo_subindex == DSH_SUB_COUNT) begin
              rdata_d = {24'h00_0000, DSH_ENTRY_COUNT};
              if (sdo_write) begin
                abort_d = 1'b1;
                code_d = DSH_ABORT_RO;
              end
            end else if (sdo_subindex == DSH_SUB_FIRST ||
                         sdo_subindex == DSH_SUB_SECOND) begin
              if (sdo_index == DSH_IDX_GEAR)
                rdata_d = (sdo_subindex == DSH_SUB_FIRST) ? gmot_q : gout_q;
              else
                rdata_d = (sdo_subindex == DSH_SUB_FIRST) ? funit_q : frev_q;
              if (sdo_write) begin
                if (sdo_index == DSH_IDX_FEED &&
                    sdo_subindex == DSH_SUB_SECOND) begin
                  if (sdo_wdata != DSH_FEED_REV_ONLY) begin
                    abort_d = 1'b1;
                    code_d = DSH_ABORT_RANGE;
                  end else begin
                    frev_d = sdo_wdata;
                    pwe_d = 1'b1;
                    pnum_d = DSH_PAR_FEED;
                    pdat_d = funit_q;
                  end
                end else if (!in_range) begin
                  abort_d = 1'b1;
                  code_d = DSH_ABORT_RANGE;
                end else begin
                  pwe_d = 1'b1;
                  pdat_d = sdo_wdata;
                  if (sdo_index == DSH_IDX_FEED) begin
                    funit_d = sdo_wdata;
                    pnum_d = DSH_PAR_FEED;
                  end else if (sdo_subindex == DSH_SUB_FIRST) begin
                    gmot_d = sdo_wdata;
                    pnum_d = DSH_PAR_GEAR_MOTOR;
                  end else begin
                    gout_d = sdo_wdata;
                    pnum_d = DSH_PAR_GEAR_OUT;
                  end
                end
              end
            end else begin
              abort_d = 1'b1;
              code_d = DSH_ABORT_NOSUB;
            end
          end else if (sdo_index == DSH_IDX_HOME) begin
            if (sdo_subindex != DSH_SUB_COUNT) begin
              abort_d = 1'b1;
              code_d = DSH_ABORT_NOSUB;
            end else begin
              rdata_d = {{24{home_q[7]}}, home_q};
              if (sdo_write) begin
                home_d = sdo_wdata[7:0];
                pwe_d = 1'b1;
                pnum_d = DSH_PAR_HOME;
                pdat_d = {{24{sdo_wdata[7]}}, sdo_wdata[7:0]};
              end
            end
          end else if (sdo_index == DSH_IDX_SAVE && sdo_write) begin
            // save command: done pulses together with the write of the last slot
            done_d = 1'b0;
            slot_d = 3'd0;
            st_d = DSH_ST_SAVE;
          end else begin
            abort_d = 1'b1;
            code_d = DSH_ABORT_NOOBJ;
          end
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_q <= DSH_ST_LOAD;
      slot_q <= 3'd0;
      gmot_q <= DSH_GEAR_MOTOR_RST;
      gout_q <= DSH_GEAR_OUT_RST;
      funit_q <= DSH_FEED_UNITS_RST;
      frev_q <= DSH_FEED_REV_RST;
      home_q <= DSH_HOME_RST;
      done_q <= 1'b0;
      abort_q <= 1'b0;
      code_q <= 32'h0000_0000;
      rdata_q <= 32'h0000_0000;
      pwe_q <= 1'b0;
      pnum_q <= 16'h0000;
      pdat_q <= 32'h0000_0000;
      nwe_q <= 1'b0;
      ndat_q <= 32'h0000_0000;
    end else begin
      st_q <= st_d;
      slot_q <= slot_d;
      gmot_q <= gmot_d;
      gout_q <= gout_d;
      funit_q <= funit_d;
      frev_q <= frev_d;
      home_q <= home_d;
      done_q <= done_d;
      abort_q <= abort_d;
      code_q <= code_d;
      rdata_q <= rdata_d;
      pwe_q <= pwe_d;
      pnum_q <= pnum_d;
      pdat_q <= pdat_d;
      nwe_q <= nwe_d;
      ndat_q <= ndat_d;
    end
  end

  // nv address is the walking slot; write lags the slot by one cycle
  logic [2:0] nadr_q;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) nadr_q <= 3'd0;
    else nadr_q <= slot_q;
  end

  assign sdo_done = done_q;
  assign sdo_abort = abort_q;
  assign sdo_abort_code = code_q;
  assign sdo_rdata = rdata_q;
  assign nv_we = nwe_q;
  assign nv_wdata = ndat_q;
  assign nv_addr = nwe_q ? nadr_q : slot_q;
  assign par_we = pwe_q;
  assign par_num = pnum_q;
  assign par_wdata = pdat_q;
  assign scaling_active = (drive_conf == DSH_CONF_MOTION);
  assign gear_num = gmot_q;
  assign gear_den = gout_q;
  assign feed_num = funit_q;
  assign feed_den = frev_q;
  assign homing_method = home_q;
  assign homing_enabled = (home_q != DSH_HOME_NONE);
endmodule
`default_nettype wire

// >>> rtl/dsh_pkg.sv
// package for the drive scaling and homing object bank
package dsh_pkg;
  // object indices and sub-indices
  localparam logic [15:0] DSH_IDX_GEAR = 16'h6091;
  localparam logic [15:0] DSH_IDX_FEED = 16'h6092;
  localparam logic [15:0] DSH_IDX_HOME = 16'h6098;
  localparam logic [15:0] DSH_IDX_SAVE = 16'h1010;
  localparam logic [7:0] DSH_SUB_COUNT = 8'h00;
  localparam logic [7:0] DSH_SUB_FIRST = 8'h01;
  localparam logic [7:0] DSH_SUB_SECOND = 8'h02;
  // entry count and reset values
  localparam logic [7:0] DSH_ENTRY_COUNT = 8'h02;
  localparam logic [31:0] DSH_GEAR_MOTOR_RST = 32'h0000_0001;
  localparam logic [31:0] DSH_GEAR_OUT_RST = 32'h0000_0001;
  localparam logic [31:0] DSH_FEED_UNITS_RST = 32'h0001_0000;
  localparam logic [31:0] DSH_FEED_REV_RST = 32'h0000_0001;
  localparam logic [7:0] DSH_HOME_RST = 8'h00;
  // value limits
  localparam logic [31:0] DSH_VAL_MIN = 32'h0000_0001;
  localparam logic [31:0] DSH_VAL_MAX = 32'h0000_FFFF;
  localparam logic [31:0] DSH_FEED_REV_ONLY = 32'h0000_0001;
  // drive configuration that enables scaling
  localparam logic [7:0] DSH_CONF_MOTION = 8'h40;
  // runtime parameter numbers and the homing method value for no homing
  localparam logic [15:0] DSH_PAR_FEED = 16'd1115;
  localparam logic [15:0] DSH_PAR_GEAR_OUT = 16'd1116;
  localparam logic [15:0] DSH_PAR_GEAR_MOTOR = 16'd1117;
  localparam logic [15:0] DSH_PAR_HOME = 16'd1130;
  localparam logic [7:0] DSH_HOME_NONE = 8'h00;
  // abort codes
  localparam logic [31:0] DSH_ABORT_RANGE = 32'h0609_0030;
  localparam logic [31:0] DSH_ABORT_NOOBJ = 32'h0602_0000;
  localparam logic [31:0] DSH_ABORT_NOSUB = 32'h0609_0011;
  localparam logic [31:0] DSH_ABORT_RO = 32'h0601_0002;
  // non-volatile image slots
  localparam int DSH_NV_SLOTS = 5;
  localparam logic [2:0] DSH_NV_GMOT = 3'd0;
  localparam logic [2:0] DSH_NV_GOUT = 3'd1;
  localparam logic [2:0] DSH_NV_FUNIT = 3'd2;
  localparam logic [2:0] DSH_NV_FREV = 3'd3;
  localparam logic [2:0] DSH_NV_HOME = 3'd4;
  typedef enum logic [2:0] {
    DSH_ST_LOAD = 3'b001,
    DSH_ST_IDLE = 3'b010,
    DSH_ST_SAVE = 3'b100
  } dsh_state_e;
endpackage

// >>> sim/dsh_bank_properties.sv
// port checker for the object bank
`timescale 1ns/1ps
`default_nettype none
module dsh_bank_props
  import dsh_pkg::*;
(
  // watched ports
  input wire logic core_clk,
  input wire logic reset,
  input wire logic sdo_write,
  input wire logic [15:0] sdo_index,
  input wire logic [7:0] sdo_subindex,
  input wire logic [31:0] sdo_wdata,
  input wire logic sdo_done,
  input wire logic sdo_abort,
  input wire logic nv_we,
  input wire logic [2:0] nv_addr,
  input wire logic [31:0] nv_wdata,
  input wire logic [31:0] nv_rdata,
  input wire logic nv_valid,
  input wire logic par_we,
  input wire logic [15:0] par_num,
  input wire logic [31:0] par_wdata,
  input wire logic [7:0] drive_conf,
  input wire logic scaling_active,
  input wire logic [31:0] gear_num,
  input wire logic signed [7:0] homing_method,
  input wire logic homing_enabled
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  logic gm_wr;
  assign gm_wr = sdo_write && sdo_index == DSH_IDX_GEAR
    && sdo_subindex == DSH_SUB_FIRST;
  // edges since reset release, saturating; the load walk is edges 1 to 5
  logic [2:0] since_q;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) since_q <= 3'h0;
    else if (since_q != 3'h7) since_q <= since_q + 3'h1;
  end
  AST_LOAD_GEAR: assert property (since_q == 3'h1 && $past(nv_valid)
    |-> par_we && par_num == DSH_PAR_GEAR_MOTOR
    && par_wdata == $past(nv_rdata) && gear_num == par_wdata)
    else $error("saved gear value not restored");
  AST_LOAD_HOME: assert property (since_q == 3'h5 && $past(nv_valid)
    |-> par_we && par_num == DSH_PAR_HOME
    && par_wdata == $past(nv_rdata) && homing_method == par_wdata[7:0])
    else $error("saved homing value not restored");
  AST_ABORT_DONE: assert property (sdo_abort |-> sdo_done)
    else $error("abort without done");
  AST_GEAR_MIRROR: assert property (
    sdo_done && !sdo_abort && $past(gm_wr)
    |-> par_we && par_num == DSH_PAR_GEAR_MOTOR
    && gear_num == $past(sdo_wdata) && par_wdata == gear_num)
    else $error("gear write not mirrored");
  AST_GEAR_RANGE: assert property (sdo_done && $past(gm_wr)
    && ($past(sdo_wdata) > DSH_VAL_MAX || $past(sdo_wdata) == 32'h0000_0000)
    |-> sdo_abort && !par_we && $stable(gear_num))
    else $error("gear range not enforced");
  AST_FEED_REV: assert property (sdo_done && $past(sdo_write
    && sdo_index == DSH_IDX_FEED && sdo_subindex == DSH_SUB_SECOND
    && sdo_wdata != DSH_FEED_REV_ONLY) |-> sdo_abort)
    else $error("feed revolution not refused");
  AST_SCALE: assert property (
    scaling_active == (drive_conf == DSH_CONF_MOTION))
    else $error("scaling flag wrong");
  AST_HOME_EN: assert property (
    homing_enabled == (homing_method != 0))
    else $error("homing flag wrong");
  AST_NV_GEAR: assert property (nv_we && nv_addr == DSH_NV_GMOT
    |-> nv_wdata == gear_num) else $error("gear save value wrong");
  AST_NV_HOME: assert property (nv_we && nv_addr == DSH_NV_HOME
    |-> nv_wdata[7:0] == homing_method) else $error("home save wrong");
  AST_SAVE_LEN: assert property (nv_we && nv_addr == DSH_NV_GMOT
    |-> ##4 nv_we && nv_addr == DSH_NV_HOME && sdo_done)
    else $error("save walk length wrong");
endmodule
`default_nettype wire

// >>> sim/dsh_nv_model.sv
// non-volatile store model, survives reset like power loss
`timescale 1ns/1ps
`default_nettype none
module dsh_nv_model (
  // store port
  input wire logic core_clk,
  input wire logic nv_we,
  input wire logic [2:0] nv_addr,
  input wire logic [31:0] nv_wdata,
  output logic [31:0] nv_rdata,
  output logic nv_valid
);
  logic [31:0] mem [8];
  logic [7:0] ok = 8'h00;
  // plain always: the valid bits start empty through their initialiser
  always @(posedge core_clk) begin
    if (nv_we) begin
      mem[nv_addr] <= nv_wdata;
      ok[nv_addr] <= 1'b1;
    end
  end
  // empty slots show junk so a wrong load cannot look right
  assign nv_valid = ok[nv_addr];
  assign nv_rdata = ok[nv_addr] ? mem[nv_addr] : 32'hA5A5_5A5A;
endmodule
`default_nettype wire

// >>> sim/tb.sv
// testbench for the object bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dsh_pkg::*;
  logic core_clk = 0, reset = 1, sdo_req = 0, sdo_write = 0, got;
  logic [15:0] sdo_index = 0, pn;
  logic [7:0] sdo_subindex = 0, drive_conf = 0;
  logic [31:0] sdo_wdata = 0, rd, ab, pd, nv_rdata, sdo_abort_code;
  logic [31:0] sdo_rdata, nv_wdata, par_wdata, gear_num, gear_den;
  logic [31:0] feed_num, feed_den;
  logic [15:0] par_num;
  logic [2:0] nv_addr;
  logic signed [7:0] homing_method;
  logic sdo_done, sdo_abort, nv_we, nv_valid, par_we, pw;
  logic scaling_active, homing_enabled;
  int mismatches = 0, n_tests = 0;
  logic [15:0] ix [7] = '{DSH_IDX_GEAR, DSH_IDX_GEAR, DSH_IDX_GEAR,
    DSH_IDX_FEED, DSH_IDX_FEED, DSH_IDX_FEED, DSH_IDX_HOME};
  logic [7:0] sx [7] = '{8'h00, 8'h01, 8'h02, 8'h00, 8'h01, 8'h02, 8'h00};
  logic [31:0] dv [7] = '{32'h2, 32'h1, 32'h1, 32'h2, 32'h1_0000, 32'h1, 0};
  logic [31:0] sv [7] = '{32'h2, 32'h5, 32'hFFFF, 32'h2, 32'h7, 32'h1,
    32'hFFFF_FFFB};
  dsh_object_bank i_dsh_object_bank (
    .core_clk(core_clk), .reset(reset), .sdo_req(sdo_req),
    .sdo_write(sdo_write), .sdo_index(sdo_index),
    .sdo_subindex(sdo_subindex), .sdo_wdata(sdo_wdata),
    .sdo_done(sdo_done), .sdo_abort(sdo_abort),
    .sdo_abort_code(sdo_abort_code), .sdo_rdata(sdo_rdata),
    .nv_we(nv_we), .nv_addr(nv_addr), .nv_wdata(nv_wdata),
    .nv_rdata(nv_rdata), .nv_valid(nv_valid), .par_we(par_we),
    .par_num(par_num), .par_wdata(par_wdata), .drive_conf(drive_conf),
    .scaling_active(scaling_active), .gear_num(gear_num),
    .gear_den(gear_den), .feed_num(feed_num), .feed_den(feed_den),
    .homing_method(homing_method), .homing_enabled(homing_enabled)
  );
  dsh_nv_model i_dsh_nv_model (
    .core_clk(core_clk), .nv_we(nv_we), .nv_addr(nv_addr),
    .nv_wdata(nv_wdata), .nv_rdata(nv_rdata), .nv_valid(nv_valid)
  );
  initial forever #2 core_clk = ~core_clk;
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task rst;
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    repeat (6) @(posedge core_clk);
  endtask
  task sdo(input logic w, input logic [15:0] x, input logic [7:0] s,
           input logic [31:0] d);
    @(posedge core_clk);
    sdo_req <= 1'b1;
    sdo_write <= w;
    sdo_index <= x;
    sdo_subindex <= s;
    sdo_wdata <= d;
    got = 1'b0;
    for (int k = 0; k < 12 && !got; k++) begin
      @(posedge core_clk);
      sdo_req <= 1'b0;
      #1;
      got = sdo_done === 1'b1;
    end
    ab = !got ? 32'hFFFF_FFFF : sdo_abort ? sdo_abort_code : 32'h0;
    rd = sdo_rdata;
    pw = par_we;
    pn = par_num;
    pd = par_wdata;
  endtask
  task wchk(input logic [15:0] x, input logic [7:0] s,
            input logic [31:0] d, input logic [31:0] e);
    sdo(1'b1, x, s, d);
    chk(ab, e);
  endtask
  task rdall(input logic [31:0] e [7]);
    for (int i = 0; i < 7; i++) begin
      sdo(1'b0, ix[i], sx[i], 0);
      chk(rd, e[i]);
    end
  endtask
  initial begin
    repeat (4000) @(posedge core_clk);
    mismatches++;
    final_report;
  end
  initial begin
    rst;
    rdall(dv);
    chk({31'h0, homing_enabled}, 0);
    $display("defaults done");
    wchk(DSH_IDX_GEAR, 1, 5, 0);
    chk({16'h0, pn}, {16'h0, DSH_PAR_GEAR_MOTOR});
    wchk(DSH_IDX_GEAR, 2, 32'hFFFF, 0);
    chk({16'h0, pn}, {16'h0, DSH_PAR_GEAR_OUT});
    wchk(DSH_IDX_GEAR, 1, 0, DSH_ABORT_RANGE);
    wchk(DSH_IDX_GEAR, 2, 32'h1_0000, DSH_ABORT_RANGE);
    chk({31'h0, pw}, 0);
    chk(gear_num, 5);
    chk(gear_den, 32'hFFFF);
    wchk(DSH_IDX_FEED, 1, 7, 0);
    chk(feed_num, 7);
    wchk(DSH_IDX_FEED, 1, 32'h1_0000, DSH_ABORT_RANGE);
    wchk(DSH_IDX_FEED, 2, 2, DSH_ABORT_RANGE);
    chk(feed_den, 1);
    wchk(DSH_IDX_FEED, 2, 1, 0);
    chk({pn, pd[15:0]}, {DSH_PAR_FEED, 16'h7});
    wchk(DSH_IDX_HOME, 0, 32'hFB, 0);
    chk({16'h0, pn}, {16'h0, DSH_PAR_HOME});
    chk({31'h0, homing_enabled}, 1);
    chk({24'h00_0000, homing_method}, 32'h0000_00FB);
    wchk(DSH_IDX_GEAR, 0, 3, DSH_ABORT_RO);
    wchk(DSH_IDX_GEAR, 3, 1, DSH_ABORT_NOSUB);
    wchk(16'h6000, 0, 1, DSH_ABORT_NOOBJ);
    $display("writes done");
    @(posedge core_clk);
    drive_conf <= 8'h40;
    @(posedge core_clk);
    #1 chk({31'h0, scaling_active}, 1);
    @(posedge core_clk);
    drive_conf <= 8'h41;
    @(posedge core_clk);
    #1 chk({31'h0, scaling_active}, 0);
    $display("config done");
    wchk(DSH_IDX_SAVE, 1, 0, 0);
    rst;
    rdall(sv);
    $display("restore done");
    final_report;
  end
endmodule
bind dsh_object_bank dsh_bank_props i_dsh_bank_props (
  .core_clk(core_clk), .reset(reset), .sdo_write(sdo_write),
  .sdo_index(sdo_index), .sdo_subindex(sdo_subindex),
  .sdo_wdata(sdo_wdata), .sdo_done(sdo_done), .sdo_abort(sdo_abort),
  .nv_we(nv_we), .nv_addr(nv_addr), .nv_wdata(nv_wdata),
  .nv_rdata(nv_rdata), .nv_valid(nv_valid), .par_we(par_we),
  .par_num(par_num), .par_wdata(par_wdata), .drive_conf(drive_conf),
  .scaling_active(scaling_active), .gear_num(gear_num),
  .homing_method(homing_method), .homing_enabled(homing_enabled)
);
`default_nettype wire
